// file: rtl/uolpc_pkg.sv
// package: register map, field positions and timing for line/power control
package uolpc_pkg;
    // register byte offsets (no offsets printed, chosen locally)
    localparam logic [7:0] OFF_LINE_STATUS  = 8'h00;
    localparam logic [7:0] OFF_LINE_CONTROL = 8'h04;
    localparam logic [7:0] OFF_POWER_CTRL   = 8'h08;
    localparam logic [7:0] OFF_EVENT_FLAGS  = 8'h0C;
    // status fields
    localparam int ST_ID        = 7;
    localparam int ST_LSTABLE   = 5;
    localparam int ST_SESS_VAL  = 3;
    localparam int ST_B_SESSEND = 2;
    localparam int ST_A_VBUSVAL = 0;
    // control fields
    localparam int CT_DP_PU  = 7;
    localparam int CT_DM_PU  = 6;
    localparam int CT_DP_PD  = 5;
    localparam int CT_DM_PD  = 4;
    localparam int CT_VB_ON  = 3;
    localparam int CT_SW_PUL = 2;
    localparam int CT_VB_CHG = 1;
    localparam int CT_VB_DIS = 0;
    // power control fields
    localparam int PW_ACT_PND = 7;
    localparam int PW_SLP_GRD = 4;
    localparam int PW_BUSY    = 3;
    localparam int PW_SUSPEND = 1;
    localparam int PW_ENABLE  = 0;
    // event flag fields (write one to clear)
    localparam int EV_ID_CHG   = 7;
    localparam int EV_LINE_CHG = 5;
    localparam int EV_ACTIVITY = 4;
    localparam int EV_SESS_CHG = 3;
    localparam int EV_SEND_CHG = 2;
    localparam int EV_VBUS_CHG = 0;
    // writable masks and reset values
    localparam logic [7:0] CTRL_WMASK  = 8'hFF;
    localparam logic [7:0] PWR_WMASK   = 8'h13;
    localparam logic [7:0] EV_MASK     = 8'hBD;
    localparam logic [7:0] CTRL_RESET  = 8'h00;
    localparam logic [7:0] PWR_RESET   = 8'h00;
    // timing
    localparam int CLK_HZ          = 20_000_000;
    localparam int STABLE_TIME_US  = 1000;
    localparam int STABLE_CYCLES   = CLK_HZ / 1_000_000 * STABLE_TIME_US;
    localparam int BUSY_DRAIN_CYC  = 4;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: rtl/uolpc_top.sv
// design: usb otg line state, pull resistor, vbus and power control block
module uolpc_top (
    input  wire logic        mclk_in,
    input  wire logic        reset_n_in,
    input  wire logic [7:0]  s_axi_awaddr_in,
    input  wire logic        s_axi_awvalid_in,
    output logic             s_axi_awready_out,
    input  wire logic [31:0] s_axi_wdata_in,
    input  wire logic [3:0]  s_axi_wstrb_in,
    input  wire logic        s_axi_wvalid_in,
    output logic             s_axi_wready_out,
    output logic [1:0]       s_axi_bresp_out,
    output logic             s_axi_bvalid_out,
    input  wire logic        s_axi_bready_in,
    input  wire logic [7:0]  s_axi_araddr_in,
    input  wire logic        s_axi_arvalid_in,
    output logic             s_axi_arready_out,
    output logic [31:0]      s_axi_rdata_out,
    output logic [1:0]       s_axi_rresp_out,
    output logic             s_axi_rvalid_out,
    input  wire logic        s_axi_rready_in,
    input  wire logic        id_pin_in,
    input  wire logic        session_valid_in,
    input  wire logic        b_session_end_in,
    input  wire logic        a_vbus_valid_in,
    input  wire logic        line_se0_in,
    input  wire logic        line_j_level_in,
    input  wire logic        bus_activity_in,
    input  wire logic        irq_generated_in,
    input  wire logic        core_active_in,
    input  wire logic [3:0]  hw_pulls_in,
    output logic             dplus_pullup_en_out,
    output logic             dminus_pullup_en_out,
    output logic             dplus_pulldown_en_out,
    output logic             dminus_pulldown_en_out,
    output logic             vbus_power_on_out,
    output logic             vbus_charge_en_out,
    output logic             vbus_discharge_en_out,
    output logic             usb_clk_gate_en_out,
    output logic             xcvr_low_power_out,
    output logic             analog_enable_out,
    output logic             pins_owned_out,
    output logic             sleep_block_out
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef enum logic [1:0] {
        UOLPC_IDLE = 2'b00,
        UOLPC_WRSP = 2'b01,
        UOLPC_RRSP = 2'b10
    } uolpc_bus_t;

    typedef struct packed {
        logic [5:0]  s1;        // first synchroniser stage
        logic [5:0]  s2;        // synchronised inputs
        logic [3:0]  lvl_prev;  // s2 cable/vbus levels one cycle earlier
        logic [1:0]  warm;      // synchroniser fill count after reset
        logic [1:0]  line_prev; // last sampled line pair
        logic [1:0]  line_stab; // last stable line pair
        logic [14:0] cnt;
        logic        stable;
        logic        act_s1;
        logic        act_s2;
        logic [7:0]  ctrl;
        logic [7:0]  pwr;
        logic [7:0]  ev;
        logic        act_pnd;
        logic [2:0]  drain;
        logic        busy;
        logic        aw_got;
        logic        w_got;
        logic [7:0]  awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        uolpc_bus_t  wst;
        uolpc_bus_t  rst;
        logic [1:0]  bresp;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [6:0]  outs;
        logic [4:0]  pmo;       // clk gate, lowpwr, analog, pins, sleep
    } uolpc_state_t;

    uolpc_state_t s_reg;
    uolpc_state_t s_next;

    // decode of a register offset, shared by read and write paths
    function automatic logic [1:0] uolpc_dec(input logic [7:0] a);
        case (a)
            uolpc_pkg::OFF_LINE_STATUS:  uolpc_dec = 2'h0;
            uolpc_pkg::OFF_LINE_CONTROL: uolpc_dec = 2'h1;
            uolpc_pkg::OFF_POWER_CTRL:   uolpc_dec = 2'h2;
            default:                     uolpc_dec = 2'h3;
        endcase
    endfunction

    function automatic logic uolpc_mapped(input logic [7:0] a);
        uolpc_mapped = (a == uolpc_pkg::OFF_LINE_STATUS)
                    || (a == uolpc_pkg::OFF_LINE_CONTROL)
                    || (a == uolpc_pkg::OFF_POWER_CTRL)
                    || (a == uolpc_pkg::OFF_EVENT_FLAGS);
    endfunction

    localparam logic [14:0] STABLE_LAST =
        15'(uolpc_pkg::STABLE_CYCLES - 1);

    logic [7:0]  stat_v;
    logic        en;
    logic [3:0]  pulls;
    logic        wr_fire;
    logic [7:0]  wlo;
    logic [1:0]  wsel;

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        s_next = s_reg;
        en     = s_reg.pwr[uolpc_pkg::PW_ENABLE];
        // two-flop synchronisers; only s2 is read below
        s_next.s1 = {id_pin_in, session_valid_in, b_session_end_in,
                     a_vbus_valid_in, line_se0_in, line_j_level_in};
        s_next.s2 = s_reg.s1;
        s_next.act_s1 = bus_activity_in;
        s_next.act_s2 = s_reg.act_s1;
        // change detection compares s2 with its own delayed copy, never s1
        s_next.lvl_prev = s_reg.s2[5:2];
        if (s_reg.warm != 2'h3) begin
            s_next.warm = s_reg.warm + 2'h1;
        end
        // status word assembled from synchronised levels
        stat_v = 8'h00;
        stat_v[uolpc_pkg::ST_ID]        = s_reg.s2[5];
        stat_v[uolpc_pkg::ST_LSTABLE]   = s_reg.stable;
        stat_v[uolpc_pkg::ST_SESS_VAL]  = s_reg.s2[4];
        stat_v[uolpc_pkg::ST_B_SESSEND] = s_reg.s2[3];
        stat_v[uolpc_pkg::ST_A_VBUSVAL] = s_reg.s2[2];
        // 1 ms stability timer restarts on any change of se0/j pair
        s_next.line_prev = s_reg.s2[1:0];
        if (s_reg.s2[1:0] != s_reg.line_prev) begin
            s_next.cnt    = 15'h0000;
            s_next.stable = 1'b0;
        end else if (s_reg.cnt != STABLE_LAST) begin
            s_next.cnt = s_reg.cnt + 15'h0001;
        end else begin
            s_next.stable = 1'b1;
        end
        // write path
        wr_fire = (s_reg.wst == UOLPC_IDLE) && s_reg.aw_got && s_reg.w_got;
        wlo  = s_reg.wdata[7:0];
        wsel = uolpc_dec(s_reg.awaddr);
        if (wr_fire && s_reg.wstrb[0]) begin
            if (wsel == 2'h1) begin
                s_next.ctrl = wlo & uolpc_pkg::CTRL_WMASK;
            end else if (wsel == 2'h2) begin
                s_next.pwr = wlo & uolpc_pkg::PWR_WMASK;
            end else if (s_reg.awaddr == uolpc_pkg::OFF_EVENT_FLAGS) begin
                s_next.ev = s_reg.ev & ~wlo;
            end
        end
        // set wins over clear: applied after the write
        if (s_reg.stable == 1'b0 && s_next.stable
            && s_reg.s2[1:0] != s_reg.line_stab) begin
            s_next.ev[uolpc_pkg::EV_LINE_CHG] = 1'b1;
        end
        if (!s_reg.stable && s_next.stable) begin
            s_next.line_stab = s_reg.s2[1:0];
        end
        // level changes; ignored until the synchroniser has filled, so
        // the idle levels seen after reset do not look like edges
        if (s_reg.warm == 2'h3 && s_reg.s2[5] != s_reg.lvl_prev[3]) begin
            s_next.ev[uolpc_pkg::EV_ID_CHG] = 1'b1;
        end
        if (s_reg.warm == 2'h3 && s_reg.s2[4] != s_reg.lvl_prev[2]) begin
            s_next.ev[uolpc_pkg::EV_SESS_CHG] = 1'b1;
        end
        if (s_reg.warm == 2'h3 && s_reg.s2[3] != s_reg.lvl_prev[1]) begin
            s_next.ev[uolpc_pkg::EV_SEND_CHG] = 1'b1;
        end
        if (s_reg.warm == 2'h3 && s_reg.s2[2] != s_reg.lvl_prev[0]) begin
            s_next.ev[uolpc_pkg::EV_VBUS_CHG] = 1'b1;
        end
        if (s_reg.act_s2) begin
            s_next.ev[uolpc_pkg::EV_ACTIVITY] = 1'b1;
        end
        // activity pending: set on activity while enabled, cleared once irq issued
        if (s_reg.act_s2 && en) begin
            s_next.act_pnd = 1'b1;
        end else if (irq_generated_in) begin
            s_next.act_pnd = 1'b0;
        end
        // busy drains for a few cycles after disable
        if (en || core_active_in) begin
            s_next.drain = 3'(uolpc_pkg::BUSY_DRAIN_CYC);
        end else if (s_reg.drain != 3'h0) begin
            s_next.drain = s_reg.drain - 3'h1;
        end
        s_next.busy = en || core_active_in || (s_reg.drain != 3'h0);
        // pin and power outputs; all but sleep block forced off while disabled
        pulls = s_reg.ctrl[uolpc_pkg::CT_SW_PUL] ? s_reg.ctrl[7:4]
                                                 : hw_pulls_in;
        s_next.outs = en ? {pulls, s_reg.ctrl[uolpc_pkg::CT_VB_ON],
                            s_reg.ctrl[uolpc_pkg::CT_VB_CHG],
                            s_reg.ctrl[uolpc_pkg::CT_VB_DIS]}
                         : 7'h00;
        s_next.pmo[4] = en && !s_reg.pwr[uolpc_pkg::PW_SUSPEND];
        s_next.pmo[3] = en && s_reg.pwr[uolpc_pkg::PW_SUSPEND];
        s_next.pmo[2] = en;
        s_next.pmo[1] = en;
        s_next.pmo[0] = s_reg.pwr[uolpc_pkg::PW_SLP_GRD]
                        && (s_reg.act_s2 || s_reg.act_pnd);
        // write channel handshake; response once both halves held
        if (s_axi_awvalid_in && s_axi_awready_out) begin
            s_next.aw_got = 1'b1;
            s_next.awaddr = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && s_axi_wready_out) begin
            s_next.w_got = 1'b1;
            s_next.wdata = s_axi_wdata_in;
            s_next.wstrb = s_axi_wstrb_in;
        end
        case (s_reg.wst)
            UOLPC_IDLE: begin
                if (wr_fire) begin
                    s_next.wst    = UOLPC_WRSP;
                    s_next.aw_got = 1'b0;
                    s_next.w_got  = 1'b0;
                    s_next.bresp  = uolpc_mapped(s_reg.awaddr)
                                  ? uolpc_pkg::RESP_OKAY
                                  : uolpc_pkg::RESP_SLVERR;
                end
            end
            UOLPC_WRSP: begin
                if (s_axi_bready_in) begin
                    s_next.wst = UOLPC_IDLE;
                end
            end
            default: s_next.wst = UOLPC_IDLE;
        endcase
        // read channel: one-cycle accept then data
        case (s_reg.rst)
            UOLPC_IDLE: begin
                if (s_axi_arvalid_in) begin
                    s_next.rst   = UOLPC_RRSP;
                    s_next.rresp = uolpc_mapped(s_axi_araddr_in)
                                 ? uolpc_pkg::RESP_OKAY
                                 : uolpc_pkg::RESP_SLVERR;
                    case (uolpc_dec(s_axi_araddr_in))
                        2'h0: s_next.rdata = {24'h000000, stat_v};
                        2'h1: s_next.rdata = {24'h000000, s_reg.ctrl};
                        2'h2: s_next.rdata = {24'h000000,
                                  s_reg.act_pnd, 2'b00,
                                  s_reg.pwr[uolpc_pkg::PW_SLP_GRD],
                                  s_reg.busy, 1'b0,
                                  s_reg.pwr[1:0]};
                        default: s_next.rdata =
                            (s_axi_araddr_in == uolpc_pkg::OFF_EVENT_FLAGS)
                            ? {24'h000000, s_reg.ev & uolpc_pkg::EV_MASK}
                            : 32'h00000000;
                    endcase
                end
            end
            UOLPC_RRSP: begin
                if (s_axi_rready_in) begin
                    s_next.rst = UOLPC_IDLE;
                end
            end
            default: s_next.rst = UOLPC_IDLE;
        endcase
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            s_reg      <= '0;
            s_reg.ctrl <= uolpc_pkg::CTRL_RESET;
            s_reg.pwr  <= uolpc_pkg::PWR_RESET;
            s_reg.wst  <= UOLPC_IDLE;
            s_reg.rst  <= UOLPC_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    // outputs straight from flops
    assign s_axi_awready_out      = !s_reg.aw_got;
    assign s_axi_wready_out       = !s_reg.w_got;
    assign s_axi_bvalid_out       = (s_reg.wst == UOLPC_WRSP);
    assign s_axi_bresp_out        = s_reg.bresp;
    assign s_axi_arready_out      = (s_reg.rst == UOLPC_IDLE);
    assign s_axi_rvalid_out       = (s_reg.rst == UOLPC_RRSP);
    assign s_axi_rdata_out        = s_reg.rdata;
    assign s_axi_rresp_out        = s_reg.rresp;
    assign dplus_pullup_en_out    = s_reg.outs[6];
    assign dminus_pullup_en_out   = s_reg.outs[5];
    assign dplus_pulldown_en_out  = s_reg.outs[4];
    assign dminus_pulldown_en_out = s_reg.outs[3];
    assign vbus_power_on_out      = s_reg.outs[2];
    assign vbus_charge_en_out     = s_reg.outs[1];
    assign vbus_discharge_en_out  = s_reg.outs[0];
    assign usb_clk_gate_en_out    = s_reg.pmo[4];
    assign xcvr_low_power_out     = s_reg.pmo[3];
    assign analog_enable_out      = s_reg.pmo[2];
    assign pins_owned_out         = s_reg.pmo[1];
    assign sleep_block_out        = s_reg.pmo[0];

    // ****************************************************************
    // assertions
    // ****************************************************************
    property p_off_outputs;
        @(posedge mclk_in) disable iff (!reset_n_in)
        !s_reg.pwr[0] |=> (s_reg.outs == 7'h00);
    endproperty
    a_off_outputs: assert property (p_off_outputs)
        else $error("outputs active while disabled");

    property p_stable_clear;
        @(posedge mclk_in) disable iff (!reset_n_in)
        (s_reg.s2[1:0] != s_reg.line_prev) |=> !s_reg.stable;
    endproperty
    a_stable_clear: assert property (p_stable_clear)
        else $error("line stable kept across change");

    property p_stable_set;
        @(posedge mclk_in) disable iff (!reset_n_in)
        $rose(s_reg.stable) |-> s_reg.cnt == STABLE_LAST;
    endproperty
    a_stable_set: assert property (p_stable_set)
        else $error("line stable set early");

    property p_sleep;
        @(posedge mclk_in) disable iff (!reset_n_in)
        !s_reg.pwr[4] |=> !sleep_block_out;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("sleep blocked without guard");

    property p_busy;
        @(posedge mclk_in) disable iff (!reset_n_in)
        s_reg.pwr[0] |=> s_reg.busy;
    endproperty
    a_busy: assert property (p_busy)
        else $error("busy low while enabled");

    property p_suspend;
        @(posedge mclk_in) disable iff (!reset_n_in)
        (s_reg.pwr[1] && s_reg.pwr[0]) |=>
            (!usb_clk_gate_en_out && xcvr_low_power_out);
    endproperty
    a_suspend: assert property (p_suspend)
        else $error("suspend not applied");

    property p_sw_pull;
        @(posedge mclk_in) disable iff (!reset_n_in)
        (s_reg.pwr[0] && s_reg.ctrl[2]) |=>
            (s_reg.outs[6:3] == $past(s_reg.ctrl[7:4]));
    endproperty
    a_sw_pull: assert property (p_sw_pull)
        else $error("software pulls not applied");

    property p_vbus;
        @(posedge mclk_in) disable iff (!reset_n_in)
        s_reg.pwr[0] |=> (vbus_power_on_out == $past(s_reg.ctrl[3]));
    endproperty
    a_vbus: assert property (p_vbus)
        else $error("vbus power mismatch");

    property p_rd_zero;
        @(posedge mclk_in) disable iff (!reset_n_in)
        s_axi_rvalid_out |-> (s_axi_rdata_out[31:8] == 24'h000000);
    endproperty
    a_rd_zero: assert property (p_rd_zero)
        else $error("upper read bits not zero");

endmodule

// file: tb/uolpc_cable_model.sv
// model: cable, vbus comparators and line receivers on the usb side
module uolpc_cable_model (
    input  wire logic       type_a_in,
    input  wire logic       vbus_up_in,
    input  wire logic [1:0] line_in,
    input  wire logic       activity_in,
    output logic            id_pin_out,
    output logic            session_valid_out,
    output logic            b_session_end_out,
    output logic            a_vbus_valid_out,
    output logic            line_se0_out,
    output logic            line_j_level_out,
    output logic            bus_activity_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // receptacle and comparator levels
    // ************************************************************
    // id floats high unless an a-type plug grounds it
    assign id_pin_out        = ~type_a_in;
    assign session_valid_out = vbus_up_in;
    assign b_session_end_out = ~vbus_up_in;
    // only an a-device sources vbus, so its valid needs both
    assign a_vbus_valid_out  = vbus_up_in & type_a_in;
    assign line_se0_out      = line_in[1];
    assign line_j_level_out  = line_in[0];
    assign bus_activity_out  = activity_in;
endmodule

// file: tb/uolpc_tb_top.sv
// testbench: register access, status, pull and power control checks
module uolpc_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // signals
    // ************************************************************
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rd, rdata;
    logic [3:0]  wstrb = 4'h0, hw_pulls = 4'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, rsp, line = 2'h0;
    logic        type_a = 1'b0, vbus_up = 1'b0, activity = 1'b0;
    logic        irq_gen = 1'b0, core_act = 1'b0;
    logic        id_pin, sess, send, avbus, se0, jlvl, act_pin;
    logic [11:0] outs;
    int          err_count = 0, total_checks = 0;

    // clock at 20 MHz
    always #25 clk = ~clk;

    uolpc_cable_model cable (.type_a_in(type_a), .vbus_up_in(vbus_up),
        .line_in(line), .activity_in(activity), .id_pin_out(id_pin),
        .session_valid_out(sess), .b_session_end_out(send),
        .a_vbus_valid_out(avbus), .line_se0_out(se0),
        .line_j_level_out(jlvl), .bus_activity_out(act_pin));

    uolpc_top dut (.mclk_in(clk), .reset_n_in(reset_n),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
        .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
        .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
        .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
        .s_axi_rready_in(rready), .id_pin_in(id_pin),
        .session_valid_in(sess), .b_session_end_in(send),
        .a_vbus_valid_in(avbus), .line_se0_in(se0),
        .line_j_level_in(jlvl), .bus_activity_in(act_pin),
        .irq_generated_in(irq_gen), .core_active_in(core_act),
        .hw_pulls_in(hw_pulls), .dplus_pullup_en_out(outs[11]),
        .dminus_pullup_en_out(outs[10]), .dplus_pulldown_en_out(outs[9]),
        .dminus_pulldown_en_out(outs[8]), .vbus_power_on_out(outs[7]),
        .vbus_charge_en_out(outs[6]), .vbus_discharge_en_out(outs[5]),
        .usb_clk_gate_en_out(outs[4]), .xcvr_low_power_out(outs[3]),
        .analog_enable_out(outs[2]), .pins_owned_out(outs[1]),
        .sleep_block_out(outs[0]));

    // ************************************************************
    // bus and compare tasks
    // ************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got,
                     exp);
        end
    endtask

    // address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge clk);
            if (!aw_done && awready === 1'b1) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready === 1'b1) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge clk); while (bvalid !== 1'b1);
        rsp = bresp;
        bready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd_reg(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        rd = rdata;
        rsp = rresp;
        rready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e);
        rd_reg(a);
        chk(rd & m, e);
    endtask

    // outputs sampled mid-cycle so register updates have landed
    task automatic ochk(input logic [11:0] m, input logic [11:0] e);
        @(negedge clk);
        chk({20'h0, outs & m}, {20'h0, e});
        @(posedge clk);
    endtask

    task automatic final_report;
        if (err_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        logic [7:0] ctab [4];
        logic [7:0] c;
        logic [3:0] p;
        ctab = '{8'hF4, 8'h0B, 8'h54, 8'h02};
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        repeat (6) @(posedge clk);
        rchk(uolpc_pkg::OFF_LINE_STATUS, 32'hFFFFFFFF, 32'h84);
        rchk(uolpc_pkg::OFF_LINE_CONTROL, 32'hFFFFFFFF, 32'h0);
        rchk(uolpc_pkg::OFF_POWER_CTRL, 32'hFFFFFFFF, 32'h0);
        rd_reg(8'h10);
        chk(rd, 32'h0);
        chk({30'h0, rsp}, {30'h0, uolpc_pkg::RESP_SLVERR});
        wr(8'h10, 32'hFF, 4'hF);
        chk({30'h0, rsp}, {30'h0, uolpc_pkg::RESP_SLVERR});
        // every cable and vbus combination
        for (int i = 0; i < 4; i++) begin
            type_a <= i[0];
            vbus_up <= i[1];
            repeat (6) @(posedge clk);
            rchk(uolpc_pkg::OFF_LINE_STATUS, 32'h8D, {24'h0, ~i[0], 3'h0,
                 i[1], ~i[1], 1'b0, i[1] & i[0]});
        end
        wr(uolpc_pkg::OFF_LINE_CONTROL, 32'hFFFFFFFF, 4'hF);
        rchk(uolpc_pkg::OFF_LINE_CONTROL, 32'hFFFFFFFF, 32'hFF);
        ochk(12'hFFF, 12'h000);
        wr(uolpc_pkg::OFF_POWER_CTRL, 32'h01, 4'hF);
        rchk(uolpc_pkg::OFF_POWER_CTRL, 32'hFFFFFFFF, 32'h09);
        ochk(12'h01E, 12'h016);
        // line state: a change mid-count must restart the 1 ms count
        wr(uolpc_pkg::OFF_EVENT_FLAGS, 32'hFF, 4'hF);
        line <= 2'b01;
        repeat (10000) @(posedge clk);
        line <= 2'b10;
        repeat (15000) @(posedge clk);
        rchk(uolpc_pkg::OFF_LINE_STATUS, 32'h20, 32'h00);
        repeat (5100) @(posedge clk);
        rchk(uolpc_pkg::OFF_LINE_STATUS, 32'h20, 32'h20);
        rchk(uolpc_pkg::OFF_EVENT_FLAGS, 32'h20, 32'h20);
        wr(uolpc_pkg::OFF_EVENT_FLAGS, 32'h20, 4'hF);
        rchk(uolpc_pkg::OFF_EVENT_FLAGS, 32'h20, 32'h00);
        // unplugging the a-type cable flips id and a-device vbus valid
        type_a <= 1'b0;
        repeat (6) @(posedge clk);
        rchk(uolpc_pkg::OFF_EVENT_FLAGS, 32'h81, 32'h81);
        // software and hardware pull ownership, vbus drive bits
        for (int i = 0; i < 4; i++) begin
            c = ctab[i];
            hw_pulls <= ~c[7:4];
            p = c[2] ? c[7:4] : ~c[7:4];
            wr(uolpc_pkg::OFF_LINE_CONTROL, {24'h0, c}, 4'hF);
            ochk(12'hFE0, {p, c[3], c[1], c[0], 5'h0});
        end
        wr(uolpc_pkg::OFF_POWER_CTRL, 32'h03, 4'hF);
        ochk(12'h018, 12'h008);
        rchk(uolpc_pkg::OFF_POWER_CTRL, 32'hFFFFFFFF, 32'h0B);
        // guarded sleep with activity, then pending cleared
        wr(uolpc_pkg::OFF_POWER_CTRL, 32'h11, 4'hF);
        activity <= 1'b1;
        repeat (6) @(posedge clk);
        ochk(12'h001, 12'h001);
        rchk(uolpc_pkg::OFF_POWER_CTRL, 32'h98, 32'h98);
        activity <= 1'b0;
        // let activity leave the synchroniser, else it re-arms pending
        repeat (4) @(posedge clk);
        irq_gen <= 1'b1;
        @(posedge clk);
        irq_gen <= 1'b0;
        repeat (6) @(posedge clk);
        rchk(uolpc_pkg::OFF_POWER_CTRL, 32'hFF, 32'h19);
        ochk(12'h001, 12'h000);
        wr(uolpc_pkg::OFF_POWER_CTRL, 32'h01, 4'hF);
        activity <= 1'b1;
        repeat (6) @(posedge clk);
        ochk(12'h001, 12'h000);
        rchk(uolpc_pkg::OFF_POWER_CTRL, 32'h80, 32'h80);
        activity <= 1'b0;
        repeat (4) @(posedge clk);
        irq_gen <= 1'b1;
        @(posedge clk);
        irq_gen <= 1'b0;
        repeat (6) @(posedge clk);
        // a write with byte 0 not strobed changes nothing
        wr(uolpc_pkg::OFF_POWER_CTRL, 32'h00, 4'h0);
        rchk(uolpc_pkg::OFF_POWER_CTRL, 32'hFF, 32'h09);
        core_act <= 1'b1;
        wr(uolpc_pkg::OFF_POWER_CTRL, 32'h00, 4'hF);
        ochk(12'hFFE, 12'h000);
        rchk(uolpc_pkg::OFF_POWER_CTRL, 32'hFF, 32'h08);
        core_act <= 1'b0;
        // once the busy drain has run out, reads zero while disabled
        repeat (10) @(posedge clk);
        rchk(uolpc_pkg::OFF_POWER_CTRL, 32'hFF, 32'h00);
        final_report();
    end

    // watchdog well beyond the roughly 30300 cycles of the sequence
    initial begin
        repeat (80000) @(posedge clk);
        err_count++;
        final_report();
    end
endmodule
